// [tcc_ctrl.sv]
// control function unit: scratchpad, conversion, backup memory and chain state
`timescale 1ns/100ps
module tcc_ctrl import tcc_pkg::*; #(
  parameter logic [7:0] RSVD_BYTE5 = 8'hFF,
  parameter logic [7:0] RSVD_BYTE6 = 8'h00,
  parameter logic [7:0] RSVD_BYTE7 = 8'h10
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // function layer events from the bus front end
  input wire logic busReset,
  input wire logic funcStart,
  input wire logic odEnter,
  output logic fastSpeedFlag,
  // bytes written by the master
  input wire logic rxValid,
  output logic rxReady,
  input wire logic [7:0] rxData,
  // read slots
  input wire logic slotReq,
  output logic slotBit,
  output logic slotAck,
  // chain query from the ROM layer
  output logic condReadRomOk,
  // temperature converter
  output logic convStart,
  output logic [1:0] convResolution,
  output logic [3:0] convBits,
  input wire logic convDone,
  input wire logic [15:0] convData,
  // backup memory
  output logic nvWrite,
  output logic nvRead,
  output logic [23:0] nvWData,
  input wire logic nvDone,
  input wire logic [23:0] nvRData,
  // port latch access from the port command decoder
  input wire logic pioWrite,
  input wire logic [1:0] pioData,
  output logic [1:0] pioLatch,
  output logic [1:0] chainState,
  // port pins, open drain
  input wire logic portAIn,
  output logic portAOut,
  output logic portAOe,
  output logic portAPullupEn,
  input wire logic portBIn,
  output logic portBOut,
  output logic portBOe,
  // supply sense pin
  input wire logic vddIn
);

  typedef struct packed {
    tcc_fsm_t fsm;
    tcc_chain_t chain;
    logic [7:0] upperLimit;
    logic [7:0] lowerLimit;
    logic [1:0] res;
    logic [15:0] temp;
    logic [1:0] latch;
    logic od;
    logic booted;
    logic convPend;
    logic nvPend;
    logic nvIsRead;
    logic waitNv;
    logic [3:0] cnt;
    logic [2:0] bitIdx;
    logic [7:0] crc;
    logic [7:0] txByte;
    logic [7:0] chainCode;
    logic slotBit;
    logic slotAck;
    logic convStart;
    logic nvWr;
    logic nvRd;
    logic condOk;
    logic [1:0] syncA;
    logic [1:0] syncB;
    logic [1:0] syncVdd;
  } tcc_ctrl_state_t;

  tcc_ctrl_state_t s_ff;
  tcc_ctrl_state_t nxt_s;
  logic fifoValid;
  logic fifoReady;
  logic [7:0] fifoData;
  logic fire;
  logic [7:0] txb;
  logic codeValid;
  tcc_chain_t codeChain;

  function automatic logic [7:0] cfgByte(input logic [1:0] res);
    return {CFG_BIT7_VALUE, res, CFG_LOW_VALUE};
  endfunction

  function automatic logic [7:0] spByte(input logic [3:0] idx, input tcc_ctrl_state_t st);
    case (idx)
      SP_ADDR_TEMP_LS: return st.temp[7:0];
      SP_ADDR_TEMP_MS: return st.temp[15:8];
      SP_ADDR_TH: return st.upperLimit;
      SP_ADDR_TL: return st.lowerLimit;
      SP_ADDR_CFG: return cfgByte(st.res);
      SP_ADDR_RSVD5: return RSVD_BYTE5;
      SP_ADDR_RSVD6: return RSVD_BYTE6;
      SP_ADDR_RSVD7: return RSVD_BYTE7;
      default: return 8'hFF;
    endcase
  endfunction

  function automatic logic [7:0] crcStep(input logic [7:0] crc, input logic din);
    return (crc >> 1) ^ (((crc[0] ^ din) == 1'b1) ? CRC_POLY : 8'h00);
  endfunction

  tcc_fifo #(.WIDTH(8), .DEPTH(RX_FIFO_DEPTH)) rxFifo (
    .core_clk(core_clk),
    .nrst(nrst),
    .flush(busReset),
    .inValid(rxValid),
    .inReady(rxReady),
    .inData(rxData),
    .outValid(fifoValid),
    .outReady(fifoReady),
    .outData(fifoData)
  );

  assign fire = fifoValid && fifoReady;

  always_comb begin
    nxt_s = s_ff;
    txb = 8'hFF;
    codeValid = 1'b0;
    codeChain = CHAIN_OFF;
    fifoReady = 1'b0;
    nxt_s.slotAck = 1'b0;
    nxt_s.convStart = 1'b0;
    nxt_s.nvWr = 1'b0;
    nxt_s.nvRd = 1'b0;
    nxt_s.syncA = {s_ff.syncA[0], portAIn};
    nxt_s.syncB = {s_ff.syncB[0], portBIn};
    nxt_s.syncVdd = {s_ff.syncVdd[0], vddIn};
    nxt_s.condOk = (s_ff.chain == CHAIN_ON) && !s_ff.syncB[1];
    if (odEnter) begin
      nxt_s.od = 1'b1;
    end
    // latch follows writes only in chain off
    if (pioWrite && s_ff.chain == CHAIN_OFF) begin
      nxt_s.latch = pioData;
    end
    if (convDone && s_ff.convPend) begin
      nxt_s.temp = convData;
      nxt_s.convPend = 1'b0;
    end
    if (nvDone && s_ff.nvPend) begin
      nxt_s.nvPend = 1'b0;
      if (s_ff.nvIsRead) begin
        nxt_s.upperLimit = nvRData[7:0];
        nxt_s.lowerLimit = nvRData[15:8];
        nxt_s.res = nvRData[16+CFG_RES_HI:16+CFG_RES_LO];
      end
    end
    if (!s_ff.booted) begin
      nxt_s.booted = 1'b1;
      nxt_s.nvRd = 1'b1;
      nxt_s.nvPend = 1'b1;
      nxt_s.nvIsRead = 1'b1;
    end
    if (slotReq) begin
      nxt_s.slotAck = 1'b1;
      nxt_s.slotBit = 1'b1;
    end
    case (s_ff.fsm)
      ST_IDLE: begin
        // stray bytes outside a command are dropped
        fifoReady = 1'b1;
        if (funcStart) begin
          nxt_s.fsm = ST_CMD;
        end
      end
      ST_CMD: begin
        fifoReady = 1'b1;
        if (fire) begin
          nxt_s.cnt = 4'h0;
          nxt_s.bitIdx = 3'h0;
          nxt_s.crc = 8'h00;
          case (fifoData)
            CMD_WRITE_SP: nxt_s.fsm = ST_WRITE;
            CMD_READ_SP: nxt_s.fsm = ST_READ_SP;
            CMD_COPY_SP: begin
              nxt_s.nvWr = 1'b1;
              nxt_s.nvPend = 1'b1;
              nxt_s.nvIsRead = 1'b0;
              nxt_s.waitNv = 1'b1;
              nxt_s.fsm = ST_WAIT;
            end
            CMD_CONVERT: begin
              // a second start while running only rejoins the wait;
              // a start in the cycle the old one finishes is a fresh start
              if (!s_ff.convPend || convDone) begin
                nxt_s.convStart = 1'b1;
                nxt_s.convPend = 1'b1;
              end
              nxt_s.waitNv = 1'b0;
              nxt_s.fsm = ST_WAIT;
            end
            CMD_READ_POWER: nxt_s.fsm = ST_POWER;
            CMD_RECALL: begin
              nxt_s.nvRd = 1'b1;
              nxt_s.nvPend = 1'b1;
              nxt_s.nvIsRead = 1'b1;
              nxt_s.waitNv = 1'b1;
              nxt_s.fsm = ST_WAIT;
            end
            CMD_CHAIN: nxt_s.fsm = ST_CHAIN_TRUE;
            default: nxt_s.fsm = ST_IDLE;
          endcase
        end
      end
      ST_WRITE: begin
        fifoReady = 1'b1;
        if (fire) begin
          case (s_ff.cnt)
            4'h0: nxt_s.upperLimit = fifoData;
            4'h1: nxt_s.lowerLimit = fifoData;
            default: nxt_s.res = fifoData[CFG_RES_HI:CFG_RES_LO];
          endcase
          nxt_s.cnt = s_ff.cnt + 4'h1;
          if (s_ff.cnt == WR_LAST_INDEX) begin
            nxt_s.fsm = ST_IDLE;
          end
        end
      end
      ST_CHAIN_TRUE: begin
        fifoReady = 1'b1;
        if (fire) begin
          nxt_s.chainCode = fifoData;
          nxt_s.fsm = ST_CHAIN_INV;
        end
      end
      ST_CHAIN_INV: begin
        fifoReady = 1'b1;
        case (s_ff.chainCode)
          CHAIN_CODE_OFF: begin
            codeValid = 1'b1;
            codeChain = CHAIN_OFF;
          end
          CHAIN_CODE_ON: begin
            codeValid = 1'b1;
            codeChain = CHAIN_ON;
          end
          CHAIN_CODE_DONE: begin
            codeValid = 1'b1;
            codeChain = CHAIN_DONE;
          end
          default: codeValid = 1'b0;
        endcase
        if (fire) begin
          if (codeValid && fifoData == ~s_ff.chainCode) begin
            nxt_s.chain = codeChain;
            nxt_s.txByte = ACK_OK;
          end else begin
            nxt_s.txByte = ACK_FAIL;
          end
          nxt_s.bitIdx = 3'h0;
          nxt_s.fsm = ST_SEND;
        end
      end
      ST_SEND: begin
        if (slotReq) begin
          nxt_s.slotBit = s_ff.txByte[s_ff.bitIdx];
          nxt_s.bitIdx = s_ff.bitIdx + 3'h1;
        end
      end
      ST_READ_SP: begin
        // data bytes then CRC, then ones
        if (s_ff.cnt < SP_CRC_INDEX) begin
          txb = spByte(s_ff.cnt, s_ff);
        end else if (s_ff.cnt == SP_CRC_INDEX) begin
          // CRC goes out as held, not inverted
          txb = s_ff.crc;
        end
        if (slotReq) begin
          nxt_s.slotBit = txb[s_ff.bitIdx];
          if (s_ff.cnt < SP_CRC_INDEX) begin
            nxt_s.crc = crcStep(s_ff.crc, txb[s_ff.bitIdx]);
          end
          nxt_s.bitIdx = s_ff.bitIdx + 3'h1;
          if (s_ff.bitIdx == 3'h7 && s_ff.cnt != SP_AFTER_CRC) begin
            nxt_s.cnt = s_ff.cnt + 4'h1;
          end
        end
      end
      ST_WAIT: begin
        // busy reads 0, done reads 1
        if (slotReq) begin
          nxt_s.slotBit = s_ff.waitNv ? !s_ff.nvPend : !s_ff.convPend;
        end
      end
      ST_POWER: begin
        if (slotReq) begin
          nxt_s.slotBit = s_ff.syncVdd[1];
        end
      end
      default: nxt_s.fsm = ST_IDLE;
    endcase
    if (busReset) begin
      nxt_s.fsm = ST_IDLE;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0;
      s_ff.fsm <= ST_IDLE;
      s_ff.chain <= CHAIN_OFF;
      s_ff.res <= RES_RESET;
      s_ff.temp <= TEMP_RESET;
      s_ff.latch <= LATCH_RESET;
      s_ff.slotBit <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign fastSpeedFlag = s_ff.od;
  assign slotBit = s_ff.slotBit;
  assign slotAck = s_ff.slotAck;
  assign condReadRomOk = s_ff.condOk;
  assign convStart = s_ff.convStart;
  assign convResolution = s_ff.res;
  assign convBits = tcc_res_bits(s_ff.res);
  assign nvWrite = s_ff.nvWr;
  assign nvRead = s_ff.nvRd;
  assign nvWData = {cfgByte(s_ff.res), s_ff.lowerLimit, s_ff.upperLimit};
  assign pioLatch = s_ff.latch;
  assign chainState = s_ff.chain;
  assign portAOut = 1'b0;
  assign portBOut = 1'b0;
  // pulldown from latch in chain off; port A also pulls down when chain finished
  assign portAOe = (s_ff.chain == CHAIN_DONE) || (s_ff.chain == CHAIN_OFF && !s_ff.latch[0]);
  assign portBOe = (s_ff.chain == CHAIN_OFF) && !s_ff.latch[1];
  assign portAPullupEn = s_ff.chain == CHAIN_ON;

  property p_cfgWrite;
    @(posedge core_clk) disable iff (!nrst)
      (s_ff.fsm == ST_WRITE && fire && s_ff.cnt == WR_LAST_INDEX && !busReset)
      |=> convResolution == $past(fifoData[6:5]) && nvWData[23:16] == {1'b0, convResolution, 5'h1F};
  endproperty
  a_cfgWrite: assert property (p_cfgWrite) else $error("configuration write not applied");

  property p_bootPins;
    @(posedge core_clk) disable iff (!nrst)
      !s_ff.booted |-> !portAOe && !portBOe && chainState == CHAIN_OFF && convBits == 4'hC;
  endproperty
  a_bootPins: assert property (p_bootPins) else $error("wrong state after reset");

  property p_chainOn;
    @(posedge core_clk) disable iff (!nrst)
      chainState == CHAIN_ON |-> portAPullupEn && !portAOe && !portBOe;
  endproperty
  a_chainOn: assert property (p_chainOn) else $error("chain on pins wrong");

  property p_condRead;
    @(posedge core_clk) disable iff (!nrst)
      condReadRomOk |-> $past(chainState) == CHAIN_ON && !$past(s_ff.syncB[1]);
  endproperty
  a_condRead: assert property (p_condRead) else $error("conditional read outside chain on");

  property p_chainDone;
    @(posedge core_clk) disable iff (!nrst)
      chainState == CHAIN_DONE |-> portAOe && !portAPullupEn && !portBOe;
  endproperty
  a_chainDone: assert property (p_chainDone) else $error("chain finished pins wrong");

  property p_odOnly;
    @(posedge core_clk) disable iff (!nrst)
      $rose(fastSpeedFlag) |-> $past(odEnter);
  endproperty
  a_odOnly: assert property (p_odOnly) else $error("overdrive without entry");

  property p_resetAbort;
    @(posedge core_clk) disable iff (!nrst)
      busReset |=> s_ff.fsm == ST_IDLE ##1 !slotAck || slotBit;
  endproperty
  a_resetAbort: assert property (p_resetAbort) else $error("bus reset did not end command");

  property p_convBusy;
    @(posedge core_clk) disable iff (!nrst)
      (s_ff.fsm == ST_WAIT && !s_ff.waitNv && s_ff.convPend && slotReq && !convDone)
      |=> slotAck && !slotBit;
  endproperty
  a_convBusy: assert property (p_convBusy) else $error("conversion busy not reported");

  property p_power;
    @(posedge core_clk) disable iff (!nrst)
      (s_ff.fsm == ST_POWER && slotReq) |=> slotAck && slotBit == $past(s_ff.syncVdd[1]);
  endproperty
  a_power: assert property (p_power) else $error("supply bit wrong");

  property p_chainAck;
    @(posedge core_clk) disable iff (!nrst)
      (s_ff.fsm == ST_CHAIN_INV && fire && fifoData != ~s_ff.chainCode && !busReset)
      |=> s_ff.txByte == ACK_FAIL && $stable(chainState);
  endproperty
  a_chainAck: assert property (p_chainAck) else $error("bad chain code accepted");

  property p_bootRecall;
    @(posedge core_clk) disable iff (!nrst)
      !s_ff.booted |=> nvRead ##0 s_ff.nvPend && s_ff.nvIsRead;
  endproperty
  a_bootRecall: assert property (p_bootRecall) else $error("no reload after reset");
endmodule

// [tcc_fifo.sv]
// small byte buffer between the bus front end and the command interpreter
`timescale 1ns/100ps
module tcc_fifo import tcc_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = RX_FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic flush,
  // filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // draining side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [CW-1:0] count;
  } tcc_fifo_state_t;

  tcc_fifo_state_t st_ff;
  tcc_fifo_state_t nxt_st;
  logic push;
  logic pop;

  assign inReady = st_ff.count != CW'(DEPTH);
  assign outValid = st_ff.count != '0;
  assign outData = st_ff.mem[st_ff.rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wrPtr] = inData;
      nxt_st.wrPtr = (st_ff.wrPtr == AW'(DEPTH - 1)) ? '0 : st_ff.wrPtr + AW'(1);
    end
    if (pop) begin
      nxt_st.rdPtr = (st_ff.rdPtr == AW'(DEPTH - 1)) ? '0 : st_ff.rdPtr + AW'(1);
    end
    if (push && !pop) begin
      nxt_st.count = st_ff.count + CW'(1);
    end else if (pop && !push) begin
      nxt_st.count = st_ff.count - CW'(1);
    end
    // a bus reset drops bytes left over from an aborted command
    if (flush) begin
      nxt_st.wrPtr = '0;
      nxt_st.rdPtr = '0;
      nxt_st.count = '0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

// [tcc_periph_model.sv]
// converter and backup memory stand-in seen by the control unit
`timescale 1ns/100ps
module tcc_periph_model import tcc_pkg::*; #(
  parameter int LAT = 60,
  parameter logic [23:0] NV_INIT = 24'h5F1122
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // converter
  input wire logic convStart,
  input wire logic [15:0] convNext,
  output logic convDone,
  output logic [15:0] convData,
  // backup memory
  input wire logic nvWrite,
  input wire logic nvRead,
  input wire logic [23:0] nvWData,
  output logic nvDone,
  output logic [23:0] nvRData,
  output logic [23:0] nvMem
);
  int convCnt;
  int nvCnt;
  logic nvRd;
  logic [15:0] convVal;
  // data is only valid with its done pulse; otherwise show a wrong value
  assign convData = convDone ? convVal : ~convVal;
  assign nvRData = nvDone ? nvMem : ~nvMem;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      convCnt <= 0;
      nvCnt <= 0;
      nvRd <= 1'b0;
      convDone <= 1'b0;
      nvDone <= 1'b0;
      convVal <= 16'h0000;
      nvMem <= NV_INIT;
    end else begin
      convDone <= (convCnt == 1);
      nvDone <= (nvCnt == 1);
      if (convCnt > 0) convCnt <= convCnt - 1;
      if (nvCnt > 0) nvCnt <= nvCnt - 1;
      if (convStart) begin
        convCnt <= LAT;
        convVal <= convNext;
      end
      if (nvWrite || nvRead) begin
        nvCnt <= LAT;
        nvRd <= nvRead;
      end
      if (nvCnt == 1 && !nvRd) nvMem <= nvWData;
    end
  end
endmodule

// [tcc_pkg.sv]
// shared constants and types for the thermometer chain control unit
package tcc_pkg;

  // control function command codes
  localparam logic [7:0] CMD_WRITE_SP = 8'h4E;
  localparam logic [7:0] CMD_READ_SP = 8'hBE;
  localparam logic [7:0] CMD_COPY_SP = 8'h48;
  localparam logic [7:0] CMD_CONVERT = 8'h44;
  localparam logic [7:0] CMD_READ_POWER = 8'hB4;
  localparam logic [7:0] CMD_RECALL = 8'hB8;
  localparam logic [7:0] CMD_CHAIN = 8'h99;

  // chain control codes (true form) and confirmation bytes
  localparam logic [7:0] CHAIN_CODE_OFF = 8'h3C;
  localparam logic [7:0] CHAIN_CODE_ON = 8'h5A;
  localparam logic [7:0] CHAIN_CODE_DONE = 8'h96;
  localparam logic [7:0] ACK_OK = 8'hAA;
  localparam logic [7:0] ACK_FAIL = 8'h00;

  // scratchpad byte addresses
  localparam logic [3:0] SP_ADDR_TEMP_LS = 4'h0;
  localparam logic [3:0] SP_ADDR_TEMP_MS = 4'h1;
  localparam logic [3:0] SP_ADDR_TH = 4'h2;
  localparam logic [3:0] SP_ADDR_TL = 4'h3;
  localparam logic [3:0] SP_ADDR_CFG = 4'h4;
  localparam logic [3:0] SP_ADDR_RSVD5 = 4'h5;
  localparam logic [3:0] SP_ADDR_RSVD6 = 4'h6;
  localparam logic [3:0] SP_ADDR_RSVD7 = 4'h7;
  localparam logic [3:0] SP_CRC_INDEX = 4'h8;
  localparam logic [3:0] SP_AFTER_CRC = 4'h9;
  localparam logic [3:0] WR_LAST_INDEX = 4'h2;

  // configuration byte layout, values after reset, CRC polynomial and receive buffer depth
  localparam int CFG_RES_HI = 6;
  localparam int CFG_RES_LO = 5;
  localparam logic CFG_BIT7_VALUE = 1'b0;
  localparam logic [4:0] CFG_LOW_VALUE = 5'h1F;
  localparam logic [1:0] RES_RESET = 2'h3;
  localparam logic [15:0] TEMP_RESET = 16'h0550;
  localparam logic [1:0] LATCH_RESET = 2'h3;
  localparam logic [7:0] CRC_POLY = 8'h8C;
  localparam int RX_FIFO_DEPTH = 4;

  typedef enum logic [1:0] {
    CHAIN_OFF = 2'h0,
    CHAIN_ON = 2'h1,
    CHAIN_DONE = 2'h3
  } tcc_chain_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_CMD = 4'h1,
    ST_WRITE = 4'h3,
    ST_CHAIN_TRUE = 4'h2,
    ST_CHAIN_INV = 4'h6,
    ST_SEND = 4'h7,
    ST_READ_SP = 4'h5,
    ST_WAIT = 4'h4,
    ST_POWER = 4'hC
  } tcc_fsm_t;

  // resolution code to converter bit count
  function automatic logic [3:0] tcc_res_bits(input logic [1:0] res);
    return 4'h9 + {2'h0, res};
  endfunction

endpackage

// [test_thermometer_chain_control_functions.sv]
// self-checking bench for the control function unit
`timescale 1ns/100ps
module test_thermometer_chain_control_functions import tcc_pkg::*;;
  localparam logic [23:0] NVI = 24'h5F1122;
  logic core_clk = 1'b0, nrst, busReset, funcStart, odEnter, fastSpeedFlag;
  logic rxValid, rxReady, slotReq, slotBit, slotAck, condReadRomOk, convStart;
  logic [7:0] rxData;
  logic [1:0] convResolution, pioData, pioLatch, chainState;
  logic [3:0] convBits;
  logic convDone, nvWrite, nvRead, nvDone, pioWrite, portAIn, portAOut, portAOe;
  logic portAPullupEn, portBIn, portBOut, portBOe, vddIn;
  logic [15:0] convData, convNext, lfsrSt = 16'h298A;
  logic [23:0] nvWData, nvRData, nvMem;
  int errTotal = 0, checksDone = 0;
  logic expQ[$];
  always #4 core_clk = ~core_clk;
  tcc_ctrl #(.RSVD_BYTE5(8'hFF), .RSVD_BYTE6(8'h00), .RSVD_BYTE7(8'h10)) i_dut (
    .core_clk, .nrst, .busReset, .funcStart, .odEnter, .fastSpeedFlag, .rxValid, .rxReady,
    .rxData, .slotReq, .slotBit, .slotAck, .condReadRomOk, .convStart, .convResolution,
    .convBits, .convDone, .convData, .nvWrite, .nvRead, .nvWData, .nvDone, .nvRData,
    .pioWrite, .pioData, .pioLatch, .chainState, .portAIn, .portAOut, .portAOe,
    .portAPullupEn, .portBIn, .portBOut, .portBOe, .vddIn);
  tcc_periph_model #(.LAT(60), .NV_INIT(NVI)) i_mod (.core_clk, .nrst, .convStart,
    .convNext, .convDone, .convData, .nvWrite, .nvRead, .nvWData, .nvDone, .nvRData, .nvMem);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errTotal++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [7:0] rnd();
    lfsrSt = {lfsrSt[14:0], lfsrSt[15] ^ lfsrSt[13] ^ lfsrSt[12] ^ lfsrSt[10]};
    return lfsrSt[7:0];
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic sendByte(input logic [7:0] b);
    int n;
    n = 0;
    rxValid <= 1'b1;
    rxData <= b;
    do begin
      @(posedge core_clk);
      n++;
    end while (rxReady !== 1'b1 && n < 50);
    check(n < 50, 1);
    rxValid <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic cmd(input logic [7:0] c);
    @(posedge core_clk);
    busReset <= 1'b1;
    @(posedge core_clk);
    busReset <= 1'b0;
    funcStart <= 1'b1;
    @(posedge core_clk);
    funcStart <= 1'b0;
    sendByte(c);
    tick(3);
  endtask
  // slots answered lsb first; the monitor compares each bit
  task automatic readByte(input logic [7:0] e);
    for (int i = 0; i < 8; i++) begin
      expQ.push_back(e[i]);
      slotReq <= 1'b1;
      @(posedge core_clk);
      slotReq <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  task automatic waitDone;
    int n;
    n = 0;
    while (convDone !== 1'b1 && nvDone !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    check(n < 300, 1);
    tick(2);
  endtask
  task automatic readSp(input logic [15:0] t, input logic [7:0] u, l, c);
    logic [7:0] b[9];
    b = '{t[7:0], t[15:8], u, l, {1'b0, c[6:5], 5'h1F}, 8'hFF, 8'h00, 8'h10, 8'h00};
    for (int i = 0; i < 8; i++)
      for (int k = 0; k < 8; k++)
        b[8] = ((b[8][0] ^ b[i][k]) ? 8'h8C : 8'h00) ^ (b[8] >> 1);
    cmd(CMD_READ_SP);
    for (int i = 0; i < 9; i++) readByte(b[i]);
    readByte(8'hFF);
  endtask
  task automatic chain(input logic [7:0] c, ci, ack);
    cmd(CMD_CHAIN);
    sendByte(c);
    sendByte(ci);
    tick(3);
    readByte(ack);
  endtask
  task automatic pio(input logic [1:0] d);
    pioWrite <= 1'b1;
    pioData <= d;
    @(posedge core_clk);
    pioWrite <= 1'b0;
    tick(5);
  endtask
  always @(posedge core_clk) begin
    if (slotAck === 1'b1) check(slotBit, expQ.size() ? expQ.pop_front() : 1'bx);
  end
  initial begin
    tick(20000);
    errTotal++;
    results();
  end
  initial begin
    logic [7:0] u, l, c;
    logic [7:0] codes[3];
    codes = '{CHAIN_CODE_ON, CHAIN_CODE_DONE, CHAIN_CODE_OFF};
    {nrst, busReset, funcStart, odEnter, rxValid, slotReq, pioWrite} = '0;
    {rxData, pioData, convNext} = '0;
    {portAIn, portBIn, vddIn} = 3'h7;
    tick(10);
    check({convBits, portAOe, portBOe, chainState, fastSpeedFlag}, 9'h180);
    nrst <= 1'b1;
    tick(80);
    check({fastSpeedFlag, convResolution}, {1'b0, NVI[22:21]});
    for (int r = 0; r < 4; r++) begin
      u = rnd();
      l = rnd();
      c = rnd();
      c[6:5] = r[1:0];
      // all three bytes before any reset
      cmd(CMD_WRITE_SP);
      sendByte(u);
      sendByte(l);
      sendByte(c);
      tick(3);
      check({convResolution, convBits}, {r[1:0], 4'h9 + r[3:0]});
    end
    readSp(16'h0550, u, l, c);
    convNext <= {rnd(), rnd()};
    // supply stays high, so busy slots stand in for the strong pullup
    cmd(CMD_CONVERT);
    readByte(8'h00);
    waitDone();
    readByte(8'hFF);
    readSp(convNext, u, l, c);
    cmd(CMD_COPY_SP);
    readByte(8'h00);
    waitDone();
    readByte(8'hFF);
    check(nvMem, {1'b0, c[6:5], 5'h1F, l, u});
    cmd(CMD_WRITE_SP);
    sendByte(~u);
    sendByte(~l);
    sendByte(~c);
    cmd(CMD_RECALL);
    readByte(8'h00);
    waitDone();
    readByte(8'hFF);
    readSp(convNext, u, l, c);
    cmd(CMD_READ_SP);
    readByte(convNext[7:0]);
    cmd(CMD_READ_POWER);
    readByte(8'hFF);
    vddIn <= 1'b0;
    tick(4);
    readByte(8'h00);
    // as a later chain member its select is still high, so it stays silent
    chain(CHAIN_CODE_ON, ~CHAIN_CODE_ON, ACK_OK);
    tick(4);
    check({chainState, condReadRomOk}, {CHAIN_ON, 1'b0});
    // first select held low, all on, then finished, then off
    portBIn <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      chain(codes[i], ~codes[i], ACK_OK);
      if (i == 0) pio(2'b00);
      check({chainState, portAPullupEn, portAOe, condReadRomOk}, {i == 0 ? 5'h0D : 5'h00}
        | {i == 1 ? 5'h1A : 5'h00});
      check(pioLatch, 2'h3);
    end
    chain(CHAIN_CODE_ON, CHAIN_CODE_ON, ACK_FAIL);
    chain(8'h11, 8'hEE, ACK_FAIL);
    check(chainState, CHAIN_OFF);
    pio(2'b10);
    check({portAOut, portBOut, portAOe, portBOe, pioLatch}, 6'h0A);
    odEnter <= 1'b1;
    @(posedge core_clk);
    odEnter <= 1'b0;
    tick(3);
    check(fastSpeedFlag, 1'b1);
    tick(5);
    check(expQ.size(), 0);
    results();
  end
endmodule
